/* dv/ioxp_checker.sv */
// Assertions on the two-wire bus, the port pins and the change alert of the expander pair.
`timescale 1ns/1ps
module ioxp_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire bus.
  input wire logic scl,
  input wire logic sclOe,
  input wire logic sdaMOe,
  input wire logic sdaSOut,
  input wire logic sdaSOe,
  // Port pins and alert.
  input wire logic [7:0] portOe,
  input wire logic [31:0] portFingers,
  input wire logic alertOut,
  input wire logic alertOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // The device end pulls the data line low only through this term.
  wire devLow = sdaSOe && !sdaSOut;

  // Each pin must enable one, two or all four fingers, never another count.
  logic fingOk;
  always_comb begin
    fingOk = 1'h1;
    for (int i = 0; i < 8; i++) begin
      if (!($countones(portFingers[i*4 +: 4]) inside {1, 2, 4})) begin
        fingOk = 1'h0;
      end
    end
  end

  // Outputs clear as soon as reset asserts, but the check only starts one edge after reset is first seen low.
  logic rstHeld;
  always_ff @(posedge clk) begin
    rstHeld <= !rst_b;
  end

  // Reset must release every line and keep the alert quiet.
  property p_rst_quiet;
    disable iff (1'h0) !rst_b && rstHeld |-> !alertOe && portOe == 8'h00 && !sclOe && !sdaMOe && !sdaSOe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("lines not released in reset");

  property p_alert_od;
    alertOut == 1'h0;
  endproperty
  a_alert_od: assert property (p_alert_od) else $error("alert driven high");

  property p_fingers;
    fingOk;
  endproperty
  a_fingers: assert property (p_fingers) else $error("illegal finger count");

  // Alert is registered, so all pins must have been outputs for a few cycles first.
  property p_out_quiet;
    (portOe == 8'hFF) [*3] |-> !alertOe;
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("alert from output pins");

  property p_scl_high;
    $rose(scl) |-> scl [*4];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");

  property p_scl_low;
    $fell(scl) |-> !scl [*4];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");

  // Data from the device may only move while the clock is low.
  property p_dev_edge;
    $changed(devLow) |-> !scl;
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved with clock high");

  property p_dev_release;
    $rose(devLow) |-> ##[1:160] !devLow;
  endproperty
  a_dev_release: assert property (p_dev_release) else $error("device holds data line");

  // Main scenarios reached.
  c_alert_set: cover property ($rose(alertOe));
  c_dev_drive: cover property ($rose(devLow));
  c_all_out: cover property (portOe == 8'hFF);
endmodule

/* dv/test_i2c_io_expander_irq_bus.sv */
// Bench driving the bus master through its software port against the expander.
`timescale 1ns/1ps
module test_i2c_io_expander_irq_bus;
  import ioxp_pkg::*;
  localparam logic [1:0] STRAP = 2'h2;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'h0;
  logic rdStb = 1'h0;
  logic [7:0] rdData;
  logic [7:0] portIn = 8'h00;
  logic [7:0] portOut;
  logic [7:0] portOe;
  logic [31:0] portFingers;
  logic alertOut;
  logic alertOe;
  int err_total = 0;
  int compares = 0;

  ioxp_if busIf();
  ioxp_device u_ioxp_device(.clk(clk), .rst_b(rst_b), .bus(busIf.dev), .addrPin(STRAP), .portIn(portIn),
    .portOut(portOut), .portOe(portOe), .portFingers(portFingers), .alertOut(alertOut), .alertOe(alertOe));
  ioxp_host u_ioxp_host(.clk(clk), .rst_b(rst_b), .bus(busIf.host), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
  ioxp_checker u_ioxp_checker(.clk(clk), .rst_b(rst_b), .scl(busIf.scl), .sclOe(busIf.sclOe),
    .sdaMOe(busIf.sdaMOe), .sdaSOut(busIf.sdaSOut), .sdaSOe(busIf.sdaSOe), .portOe(portOe),
    .portFingers(portFingers), .alertOut(alertOut), .alertOe(alertOe));

  // Clock of 100 ns.
  always #50 clk = ~clk;

  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes last one clock; an idle edge follows so no strobe is set twice in one step.
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    @(posedge clk);
    wrStb <= 1'h0;
    @(posedge clk);
  endtask

  task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rdStb <= 1'h1;
    @(posedge clk);
    rdStb <= 1'h0;
    @(posedge clk);
    d = rdData;
  endtask

  // One byte order, then a bounded poll until the master is idle again.
  task automatic go(input logic [7:0] ctrl, output logic [7:0] s);
    sw_wr(M_CTRL, ctrl);
    s = 8'h01;
    for (int i = 0; i < 400 && s[0] !== 1'h0; i++) sw_rd(M_STATUS, s);
    if (s[0] !== 1'h0) err_total++;
  endtask

  task automatic start(input logic dir);
    logic [7:0] s;
    sw_wr(M_CMD, {ADDR_BASE, STRAP, dir});
    go(8'h09, s);
    chk({31'h0, s[1]}, 32'h0);
  endtask

  // Register write: command byte, then n copies of the data byte, stop on the last.
  task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] d, input int n);
    logic [7:0] s;
    start(DIR_WRITE);
    sw_wr(M_WDATA, cmd);
    go(8'h01, s);
    for (int i = 0; i < n; i++) begin
      sw_wr(M_WDATA, d);
      go(i == n - 1 ? 8'h05 : 8'h01, s);
      chk({31'h0, s[1]}, 32'h0);
    end
  endtask

  // Register read through a repeated start; the last byte is left unacknowledged.
  task automatic reg_rd(input logic [7:0] cmd, input logic [7:0] exp, input int n);
    logic [7:0] s;
    start(DIR_WRITE);
    sw_wr(M_WDATA, cmd);
    go(8'h01, s);
    start(DIR_READ);
    for (int i = 0; i < n; i++) begin
      go(i == n - 1 ? 8'h07 : 8'h03, s);
      sw_rd(M_RDATA, s);
      chk({24'h0, s}, {24'h0, exp});
    end
  endtask

  // The pin synchroniser and alert register need a few clocks, so allow a margin.
  task automatic alert_is(input logic v);
    repeat (20) @(posedge clk);
    chk({31'h0, alertOe}, {31'h0, v});
  endtask

  task automatic fingers_are(input logic [15:0] drv);
    logic [1:0] c;
    // Let one edge pass so the registered finger enables have settled.
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      c = drv[i*2 +: 2];
      chk($countones(portFingers[i*4 +: 4]), c == 2'h0 ? 1 : c == 2'h3 ? 4 : 2);
    end
  endtask

  // Main sequence: defaults, masking, clearing, direction change, drive, latch, reset.
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    chk({24'h0, portOe}, 32'h0);
    fingers_are(RST_DRIVE);
    reg_rd(CMD_MASK, RST_MASK, 1);
    portIn <= 8'h02;
    alert_is(1'h0);
    reg_wr(CMD_MASK, 8'hFC, 2);
    alert_is(1'h1);
    reg_rd(CMD_INPUT, 8'h02, 2);
    alert_is(1'h0);
    portIn <= 8'h00;
    alert_is(1'h1);
    portIn <= 8'h02;
    alert_is(1'h0);
    reg_wr(CMD_CONFIG, 8'h00, 1);
    reg_wr(CMD_OUTPUT, 8'hA5, 1);
    chk({16'h0, portOe, portOut}, 32'h0000_FFA5);
    portIn <= 8'h03;
    alert_is(1'h0);
    reg_wr(CMD_CONFIG, 8'hFF, 1);
    alert_is(1'h1);
    reg_rd(CMD_INPUT, 8'h03, 1);
    alert_is(1'h0);
    reg_wr(CMD_DRIVE_LO, 8'hE4, 1);
    fingers_are({RST_DRIVE[15:8], 8'hE4});
    reg_wr(CMD_LATCH, 8'h01, 1);
    portIn <= 8'h02;
    alert_is(1'h1);
    portIn <= 8'h03;
    alert_is(1'h1);
    reg_rd(CMD_INPUT, 8'h02, 1);
    alert_is(1'h0);
    portIn <= 8'h01;
    alert_is(1'h1);
    rst_b <= 1'h0;
    @(posedge clk);
    @(posedge clk);
    chk({23'h0, alertOe, portOe}, 32'h0);
    rst_b <= 1'h1;
    @(posedge clk);
    reg_rd(CMD_CONFIG, RST_CONFIG, 1);
    report_and_stop();
  end

  // Watchdog: the whole sequence needs well under half of this span.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule

/* logic/ioxp_device.sv */
// Expander end: bus slave, registers, port pins and change alert.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Input pin edge raises the alert.
// - Non-latched alert clears on return or read.
// - Port read clears alert at ack bit.
// - Changes during ack pulse may be lost.
// - Changes after clear alert again.
// - Output pins never raise the alert.
// - Output to input mismatch raises alert.
// - Alert is open drain, low only.
// - Latched inputs clear only on port read.
// - Master makes a fresh start only on idle bus.
// - Write: address, command byte selects register.
// - Unlimited data bytes per write.
// - Read begins with write of command.
// - Repeated start, direction one, register data.
// - Unlimited read bytes, last one not acknowledged.
// - Input register captured at ack rising edge.
// - Per-pin drive strength from four codes: one, two or four fingers.
// - Code 10b enables two fingers only.
// - Reset assertion initialises registers and machine.
// - Masked inputs never assert the alert.
// - Reset held keeps everything at defaults.
module ioxp_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire bus.
  ioxp_if.dev bus,
  // Address straps.
  input wire logic [1:0] addrPin,
  // Port pins.
  input wire logic [7:0] portIn,
  output logic [7:0] portOut,
  output logic [7:0] portOe,
  output logic [31:0] portFingers,
  // Open-drain alert.
  output logic alertOut,
  output logic alertOe
);
  import ioxp_pkg::*;

  typedef enum logic [2:0] {
    IOXP_IDLE = 3'b000, IOXP_ADDR = 3'b001, IOXP_CMD = 3'b010,
    IOXP_WR = 3'b011, IOXP_RD = 3'b100, IOXP_SKIP = 3'b101
  } ioxp_state_t;

  logic [1:0] sclSync, sdaSync;
  logic [7:0] pinSync1, pinSync2;
  logic [1:0] addrSync1, addrSync2;
  logic sclPrev, sdaPrev;
  logic [7:0] outReg, polReg, cfgReg, latchReg, maskReg, inReg, srcFlag, latched;
  logic [15:0] drvReg;
  ioxp_state_t state;
  logic [7:0] shifter, cmdReg, txByte;
  logic [3:0] bitCnt;
  logic ackPhase;

  wire sclRise = sclSync[1] && !sclPrev;
  wire sclFall = !sclSync[1] && sclPrev;
  wire startCond = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
  wire stopCond = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];
  wire [7:0] pinNow = pinSync2;

  // Two-flop synchronisers on everything that comes from outside.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      pinSync1 <= 8'h00_00;
      pinSync2 <= 8'h00_00;
      addrSync1 <= 2'b00;
      addrSync2 <= 2'b00;
    end else begin
      sclSync <= {sclSync[0], bus.scl};
      sdaSync <= {sdaSync[0], bus.sda};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      pinSync1 <= portIn;
      pinSync2 <= pinSync1;
      addrSync1 <= addrPin;
      addrSync2 <= addrSync1;
    end
  end

  // Read value of a register; latched inputs show the held level.
  function automatic logic [7:0] readReg(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00_00;
    case (c)
      CMD_INPUT: v = ((latchReg & latched) | (~latchReg & pinNow)) ^ polReg;
      CMD_OUTPUT: v = outReg;
      CMD_POLARITY: v = polReg;
      CMD_CONFIG: v = cfgReg;
      CMD_DRIVE_LO: v = drvReg[7:0];
      CMD_DRIVE_HI: v = drvReg[15:8];
      CMD_LATCH: v = latchReg;
      CMD_MASK: v = maskReg;
      CMD_STATUS: v = srcFlag & ~maskReg;
      default: v = 8'h00_00;
    endcase
    return v;
  endfunction

  // Slave protocol; the ack phase is the ninth clock of each byte.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IOXP_IDLE;
      shifter <= 8'h00_00;
      cmdReg <= 8'h00_00;
      txByte <= 8'h00_00;
      bitCnt <= 4'h0_0;
      ackPhase <= 1'b0;
      bus.sdaSOut <= 1'b1;
      bus.sdaSOe <= 1'b0;
    end else if (startCond) begin
      state <= IOXP_ADDR;
      bitCnt <= 4'h0_0;
      ackPhase <= 1'b0;
      bus.sdaSOe <= 1'b0;
    end else if (stopCond) begin
      state <= IOXP_IDLE;
      bus.sdaSOe <= 1'b0;
    end else if (state != IOXP_IDLE && state != IOXP_SKIP) begin
      if (sclRise && !ackPhase) begin
        shifter <= {shifter[6:0], sdaSync[1]};
        bitCnt <= bitCnt + 4'h0_1;
      end else if (sclRise && ackPhase && state == IOXP_RD && sdaSync[1]) begin
        state <= IOXP_SKIP;
      end else if (sclFall && ackPhase) begin
        ackPhase <= 1'b0;
        bitCnt <= 4'h0_0;
        bus.sdaSOe <= 1'b0;
        if (state == IOXP_RD) begin
          bus.sdaSOe <= 1'b1;
          bus.sdaSOut <= txByte[7];
          txByte <= {txByte[6:0], 1'b0};
        end
      end else if (sclFall && bitCnt == 4'h0_8) begin
        ackPhase <= 1'b1;
        bus.sdaSOe <= 1'b0;
        case (state)
          IOXP_ADDR: begin
            if (shifter[7:1] == {ADDR_BASE, addrSync2}) begin
              bus.sdaSOe <= 1'b1;
              bus.sdaSOut <= 1'b0;
              state <= (shifter[0] == DIR_READ) ? IOXP_RD : IOXP_CMD;
              txByte <= readReg(cmdReg);
            end else begin
              state <= IOXP_SKIP;
            end
          end
          IOXP_CMD: begin
            bus.sdaSOe <= 1'b1;
            bus.sdaSOut <= 1'b0;
            cmdReg <= shifter;
            state <= IOXP_WR;
          end
          IOXP_WR: begin
            bus.sdaSOe <= 1'b1;
            bus.sdaSOut <= 1'b0;
          end
          IOXP_RD: begin
            txByte <= readReg(cmdReg);
          end
          default: state <= IOXP_SKIP;
        endcase
      end else if (sclFall && state == IOXP_RD && !ackPhase) begin
        bus.sdaSOut <= txByte[7];
        txByte <= {txByte[6:0], 1'b0};
      end
    end
  end

  // Register write at the end of each data byte, and the port-read clear point at the ack rise.
  wire wrStrobe = sclFall && !ackPhase && bitCnt == 4'h0_8 && state == IOXP_WR;
  wire portReadAck = sclRise && ackPhase && state == IOXP_RD && cmdReg == CMD_INPUT;

  // Writable registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outReg <= RST_OUTPUT;
      polReg <= RST_POLARITY;
      cfgReg <= RST_CONFIG;
      drvReg <= RST_DRIVE;
      latchReg <= RST_LATCH;
      maskReg <= RST_MASK;
    end else if (wrStrobe) begin
      case (cmdReg)
        CMD_OUTPUT: outReg <= shifter;
        CMD_POLARITY: polReg <= shifter;
        CMD_CONFIG: cfgReg <= shifter;
        CMD_DRIVE_LO: drvReg[7:0] <= shifter;
        CMD_DRIVE_HI: drvReg[15:8] <= shifter;
        CMD_LATCH: latchReg <= shifter;
        CMD_MASK: maskReg <= shifter;
        default: outReg <= outReg;
      endcase
    end
  end

  // Input snapshot, latch hold and sticky change flags.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inReg <= 8'h00_00;
      latched <= 8'h00_00;
      srcFlag <= 8'h00_00;
    end else begin
      if (portReadAck) begin
        inReg <= pinNow;
        latched <= pinNow;
      end else begin
        latched <= (latched & ~srcFlag & ~(cfgReg & latchReg)) | (latched & srcFlag) | (pinNow & ~srcFlag & cfgReg & latchReg & ~(pinNow ^ inReg));
      end
      for (int i = 0; i < 8; i++) begin
        if (cfgReg[i] && pinNow[i] != inReg[i] && !(portReadAck)) begin
          srcFlag[i] <= 1'b1;
          if (latchReg[i] && !srcFlag[i])
            latched[i] <= pinNow[i];
        end else if (!cfgReg[i]) begin
          srcFlag[i] <= 1'b0;
        end else if (portReadAck) begin
          srcFlag[i] <= 1'b0;
        end else if (!latchReg[i] && pinNow[i] == inReg[i]) begin
          srcFlag[i] <= 1'b0;
        end
      end
    end
  end

  // Pin drive; output data and fingers come from registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portOut <= 8'h00_00;
      portOe <= 8'h00_00;
      portFingers <= 32'hFFFF_FFFF; // All four fingers, as the reset drive code selects.
      alertOe <= 1'b0;
    end else begin
      portOut <= outReg;
      portOe <= ~cfgReg;
      for (int i = 0; i < 8; i++) begin
        case (drvReg[2*i +: DRV_W])
          2'b00: portFingers[4*i +: 4] <= 4'b0001;
          2'b01: portFingers[4*i +: 4] <= 4'b0011;
          DRV_HALF: portFingers[4*i +: 4] <= 4'b0011;
          default: portFingers[4*i +: 4] <= 4'b1111;
        endcase
      end
      alertOe <= |(srcFlag & ~maskReg & cfgReg);
    end
  end

  assign alertOut = 1'b0;
endmodule

/* logic/ioxp_host.sv */
// Bus master end: drives the two-wire bus on orders written to its own registers.
`timescale 1ns/1ps
module ioxp_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire bus.
  ioxp_if.host bus,
  // Software port.
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData
);
  import ioxp_pkg::*;

  typedef enum logic [2:0] {
    IOXH_IDLE = 3'b000, IOXH_START = 3'b001, IOXH_BITS = 3'b010,
    IOXH_ACK = 3'b011, IOXH_STOP = 3'b100
  } ioxh_state_t;

  // Control: [0] go, [1] read, [2] stop after, [3] start (fresh or repeated); cmd = address/direction byte.
  logic [7:0] cmdByte, txData, rxData, count;
  logic [3:0] ctrl;
  // Held from a start that this master made until its stop, so that a repeated start need not see an idle bus.
  logic busy, nackSeen, ownBus;
  ioxh_state_t state;
  logic [2:0] phase;
  logic [7:0] sh;
  logic [3:0] bitN;
  logic [1:0] sclS, sdaS;
  logic [7:0] divCnt;

  // Synchronise the wired bus lines.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclS <= 2'b11;
      sdaS <= 2'b11;
    end else begin
      sclS <= {sclS[0], bus.scl};
      sdaS <= {sdaS[0], bus.sda};
    end
  end

  // Software registers and read-back.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdByte <= 8'h00_00;
      txData <= 8'h00_00;
      ctrl <= 4'h0_0;
      rdData <= 8'h00_00;
    end else begin
      ctrl[0] <= 1'b0;
      if (wrStb && !busy) begin
        case (addr)
          M_CTRL: ctrl <= wrData[3:0];
          M_CMD: cmdByte <= wrData;
          M_WDATA: txData <= wrData;
          default: ctrl[0] <= 1'b0;
        endcase
      end
      if (rdStb) begin
        case (addr)
          M_STATUS: rdData <= {6'h00, nackSeen, busy};
          M_RDATA: rdData <= rxData;
          M_COUNT: rdData <= count;
          M_CMD: rdData <= cmdByte;
          default: rdData <= 8'h00_00;
        endcase
      end
    end
  end

  // One byte per order: optional start, eight bits, ack, optional stop.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IOXH_IDLE;
      busy <= 1'b0;
      nackSeen <= 1'b0;
      ownBus <= 1'b0;
      rxData <= 8'h00_00;
      count <= 8'h00_00;
      phase <= 3'h0;
      sh <= 8'h00_00;
      bitN <= 4'h0_0;
      divCnt <= 8'h00_00;
      bus.sclOut <= 1'b1;
      bus.sclOe <= 1'b0;
      bus.sdaMOut <= 1'b1;
      bus.sdaMOe <= 1'b0;
    end else if (state == IOXH_IDLE) begin
      // A fresh start waits for an idle bus; a repeated start or a plain byte goes at once.
      if (ctrl[0] && (!ctrl[3] || ownBus || (sclS[1] && sdaS[1]))) begin
        busy <= 1'b1;
        ownBus <= ownBus || ctrl[3];
        sh <= ctrl[1] ? 8'h00_FF : (ctrl[3] ? cmdByte : txData);
        state <= ctrl[3] ? IOXH_START : IOXH_BITS;
        phase <= 3'h0;
        bitN <= 4'h0_0;
        divCnt <= 8'h00_00;
      end
    end else if (divCnt != 8'(SCL_HALF - 1)) begin
      divCnt <= divCnt + 8'h00_01;
    end else begin
      divCnt <= 8'h00_00;
      phase <= phase + 3'h1;
      case (state)
        IOXH_START: begin
          case (phase)
            3'h0: begin bus.sdaMOe <= 1'b0; bus.sclOe <= 1'b0; end
            3'h1: bus.sdaMOe <= 1'b1;
            3'h2: bus.sdaMOut <= 1'b0;
            default: begin bus.sclOe <= 1'b1; bus.sclOut <= 1'b0; state <= IOXH_BITS; phase <= 3'h0; end
          endcase
        end
        IOXH_BITS: begin
          case (phase)
            3'h0: begin bus.sdaMOe <= !ctrl[1] || ctrl[3]; bus.sdaMOut <= sh[7]; end
            3'h1: bus.sclOe <= 1'b0;
            3'h2: rxData <= {rxData[6:0], sdaS[1]};
            default: begin
              bus.sclOe <= 1'b1;
              sh <= {sh[6:0], 1'b1};
              bitN <= bitN + 4'h0_1;
              phase <= 3'h0;
              if (bitN == 4'h0_7) state <= IOXH_ACK;
            end
          endcase
        end
        IOXH_ACK: begin
          case (phase)
            // Read data is acknowledged unless this is the last byte.
            3'h0: begin bus.sdaMOe <= ctrl[1] && !ctrl[3] && !ctrl[2]; bus.sdaMOut <= 1'b0; end
            3'h1: bus.sclOe <= 1'b0;
            3'h2: nackSeen <= sdaS[1];
            default: begin
              bus.sclOe <= 1'b1;
              count <= count + 8'h00_01;
              phase <= 3'h0;
              if (ctrl[2]) state <= IOXH_STOP;
              else begin state <= IOXH_IDLE; busy <= 1'b0; end
            end
          endcase
        end
        IOXH_STOP: begin
          case (phase)
            3'h0: begin bus.sdaMOe <= 1'b1; bus.sdaMOut <= 1'b0; end
            3'h1: bus.sclOe <= 1'b0;
            3'h2: bus.sdaMOe <= 1'b0;
            default: begin
              state <= IOXH_IDLE;
              busy <= 1'b0;
              ownBus <= 1'b0;
            end
          endcase
        end
        default: state <= IOXH_IDLE;
      endcase
    end
  end
endmodule

/* shared/ioxp_if.sv */
// Interface joining the expander and the bus master over the two-wire bus.
`timescale 1ns/1ps
interface ioxp_if;
  logic sclOut;
  logic sclOe;
  logic sdaMOut;
  logic sdaMOe;
  logic sdaSOut;
  logic sdaSOe;
  // Open-drain wired-AND with pull-up.
  wire scl = !(sclOe && !sclOut);
  wire sda = !((sdaMOe && !sdaMOut) || (sdaSOe && !sdaSOut));
  modport dev (input scl, input sda, output sdaSOut, output sdaSOe);
  modport host (input scl, input sda, output sclOut, output sclOe, output sdaMOut, output sdaMOe);
endinterface

/* shared/ioxp_pkg.sv */
// Package with register map, fields, reset values and bus constants of the I/O expander.
package ioxp_pkg;
  // Register command codes.
  localparam logic [7:0] CMD_INPUT = 8'h00_00;
  localparam logic [7:0] CMD_OUTPUT = 8'h00_01;
  localparam logic [7:0] CMD_POLARITY = 8'h00_02;
  localparam logic [7:0] CMD_CONFIG = 8'h00_03;
  localparam logic [7:0] CMD_DRIVE_LO = 8'h00_40;
  localparam logic [7:0] CMD_DRIVE_HI = 8'h00_41;
  localparam logic [7:0] CMD_LATCH = 8'h00_42;
  localparam logic [7:0] CMD_MASK = 8'h00_45;
  localparam logic [7:0] CMD_STATUS = 8'h00_46;
  // Reset values.
  localparam logic [7:0] RST_OUTPUT = 8'h00_FF;
  localparam logic [7:0] RST_POLARITY = 8'h00_00;
  localparam logic [7:0] RST_CONFIG = 8'h00_FF;
  localparam logic [15:0] RST_DRIVE = 16'hFFFF;
  localparam logic [7:0] RST_LATCH = 8'h00_00;
  localparam logic [7:0] RST_MASK = 8'h00_FF;
  // Drive strength field width and the half-drive code.
  localparam int DRV_W = 2;
  localparam logic [1:0] DRV_HALF = 2'b10;
  // Seven-bit bus address base; low two bits come from the address straps.
  localparam logic [4:0] ADDR_BASE = 5'h0_0E;
  // Direction bit values.
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // Master side command register offsets.
  localparam logic [3:0] M_CTRL = 4'h0_0;
  localparam logic [3:0] M_CMD = 4'h0_1;
  localparam logic [3:0] M_WDATA = 4'h0_2;
  localparam logic [3:0] M_STATUS = 4'h0_3;
  localparam logic [3:0] M_RDATA = 4'h0_4;
  localparam logic [3:0] M_COUNT = 4'h0_5;
  // Master clock divider: one phase, a quarter of the clock period, in system clocks.
  localparam int SCL_HALF = 4;
endpackage
